// ===== logic/hlc_pkg.sv
package hlc_pkg;

   // Register byte offsets, used directly as Wishbone byte addresses
   localparam logic [7:0] HLC_ADDR_HOLD_CFG   = 8'h5c;
   localparam logic [7:0] HLC_ADDR_HOLD_F0    = 8'h5d;
   localparam logic [7:0] HLC_ADDR_HOLD_F1    = 8'h5e;
   localparam logic [7:0] HLC_ADDR_HOLD_F2    = 8'h5f;
   localparam logic [7:0] HLC_ADDR_SEC_PATH   = 8'h60;
   localparam logic [7:0] HLC_ADDR_SEC_LOCK   = 8'h61;
   localparam logic [7:0] HLC_ADDR_CUR_F0     = 8'h62;
   localparam logic [7:0] HLC_ADDR_CUR_F1     = 8'h63;
   localparam logic [7:0] HLC_ADDR_CUR_F2     = 8'h64;
   localparam logic [7:0] HLC_ADDR_SOFT_LIM   = 8'h65;
   localparam logic [7:0] HLC_ADDR_HARD_L0    = 8'h66;
   localparam logic [7:0] HLC_ADDR_HARD_L1    = 8'h67;
   localparam logic [7:0] HLC_ADDR_PHASE_0    = 8'h68;
   localparam logic [7:0] HLC_ADDR_PHASE_1    = 8'h69;
   localparam logic [7:0] HLC_ADDR_APLL_BW    = 8'h6a;

   // Reset values
   localparam logic [7:0]  HLC_RST_HOLD_CFG  = 8'h44;
   localparam logic [23:0] HLC_RST_HOLD_FREQ = 24'h000000;
   localparam logic [3:0]  HLC_RST_SEC_INPUT = 4'h4;
   localparam logic [2:0]  HLC_RST_DAMPING   = 3'h3;
   localparam logic [1:0]  HLC_RST_LOCK_BW   = 2'h0;
   localparam logic [7:0]  HLC_RST_SOFT_LIM  = 8'h80;
   localparam logic [15:0] HLC_RST_HARD_LIM  = 16'h00ab;
   localparam logic [1:0]  HLC_RST_APLL_BW   = 2'h1;

   // Field positions in the method register
   localparam int HLC_BIT_MANUAL   = 7;
   localparam int HLC_BIT_AVG_ON   = 6;
   localparam int HLC_BIT_FAST     = 5;
   localparam int HLC_BIT_READBACK = 4;

   // Offset acquisition method applied by the loop
   typedef enum logic [1:0] {
      HLC_ACQ_INSTANT = 2'b00,
      HLC_ACQ_SLOW    = 2'b01,
      HLC_ACQ_FAST    = 2'b10,
      HLC_ACQ_MANUAL  = 2'b11
   } hlc_acq_t;

   // Configuration handed to the loop logic
   typedef struct packed {
      hlc_acq_t    holdover_method;
      logic [1:0]  temp_holdover_method;
      logic [23:0] holdover_offset_value;
      logic [3:0]  secondary_analog_input_sel;
      logic [1:0]  secondary_mixed_path_sel;
      logic [1:0]  secondary_pdh_path_sel;
      logic [2:0]  secondary_locked_damping;
      logic [1:0]  secondary_locked_bandwidth;
      logic        loss_on_hard_alarm;
      logic [6:0]  soft_limit_value;
      logic [15:0] hard_limit_value;
      logic [1:0]  primary_analog_bandwidth;
      logic [1:0]  secondary_analog_bandwidth;
   } hlc_cfg_t;

   // Status arriving from the loop logic
   typedef struct packed {
      logic [23:0] current_loop_frequency;
      logic [15:0] phase_error_value;
      logic [23:0] slow_avg_offset;
      logic [23:0] fast_averaging_offset;
   } hlc_sts_t;

endpackage : hlc_pkg

// ===== logic/hlc_regs.sv
`timescale 1ns/1ps
// Operation
// - Manual bit set selects manual offset, else averaging off is instantaneous, slow or fast.
// - Read-back bit chooses written value or the acquired slow or fast average on holdover reads.
// - Holdover offset is a signed 24-bit value in three bytes, 0.000011 ppm per step.
// - Secondary analog input select is four bits, top-bit codes reserved, default 0100.
// - Mixed-rate path select low bit resets from the line-standard strap.
// - PDH path select low bit resets from the line-standard strap.
// - Locked damping code 001..101 valid, default 011, others reserved.
// - Locked bandwidth code, default 00 meaning 18 Hz.
// - Seven-bit soft limit shared by both loops, 0.724 ppm per step.
// - Sixteen-bit hard limit in two bytes, 0.0014 ppm per step.
// - Loss-on-hard-alarm bit, default 1, makes a hard alarm declare the loop unlocked.
// - Phase error is a 16-bit two's-complement read-only value in two bytes, 0.61 ns per step.
// - Each analog loop has a two-bit bandwidth field, default 01, in one register.
module hlc_regs
   import hlc_pkg::*;
(
   // System clock, reset and enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Asynchronous strap pin
   input  wire logic        line_standard_strap_i,
   // Register bus
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [7:0]  wb_dat_i,
   input  wire logic        wb_sel_i,
   output logic      [7:0]  wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // Loop logic side
   input  wire hlc_sts_t    sts_i,
   input  wire logic [1:0]  hard_alarm_i,
   // Configuration out and lock loss
   output hlc_cfg_t         cfg_o,
   output logic      [1:0]  loop_unlocked_o
);

   // Strap synchroniser; first stage feeds only the second
   logic strap_s1_q;
   logic strap_s2_q;
   // Marks the one cycle after reset in which the strap is copied
   logic strap_seen_q;
   logic strap_seen_d;

   // Writable state
   logic [7:0]  hold_cfg_q,  hold_cfg_d;
   logic [23:0] hold_freq_q, hold_freq_d;
   logic [3:0]  sec_in_q,    sec_in_d;
   logic [1:0]  mixed_q,     mixed_d;
   logic [1:0]  pdh_q,       pdh_d;
   logic [2:0]  damp_q,      damp_d;
   logic [1:0]  lbw_q,       lbw_d;
   logic [7:0]  soft_q,      soft_d;
   logic [15:0] hard_q,      hard_d;
   logic [1:0]  p_bw_q,      p_bw_d;
   logic [1:0]  s_bw_q,      s_bw_d;

   // Bus state
   logic [7:0] rdata_q, rdata_d;
   logic       ack_q,   ack_d;
   logic       err_q,   err_d;
   wire logic [1:0] unl_all;

   // Request decode and holdover read-back source
   logic       req;
   logic       wr;
   logic       hit;
   logic [23:0] hold_rd;

   // A request is taken only while no answer stands, so a master that holds
   // stb through its ack edge is not taken twice; the held stb is taken again
   // after the one idle cycle in which ack falls.
   assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
   assign wr  = req && wb_we_i && wb_sel_i;

   // Strap path: two flops, no reset needed on data
   // The pin is asynchronous, so only the second flop feeds any logic
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         strap_s1_q <= line_standard_strap_i;
         strap_s2_q <= strap_s1_q;
      end
   end

   // Holdover read-back source selection
   // Averaged values are live from the loop, not captured at the bus
   always_comb begin
      if (!hold_cfg_q[HLC_BIT_READBACK]) begin
         hold_rd = hold_freq_q;
      end else if (hold_cfg_q[HLC_BIT_FAST]) begin
         hold_rd = sts_i.fast_averaging_offset;
      end else begin
         hold_rd = sts_i.slow_avg_offset;
      end
   end

   // Register write decode. Later assignments win, so a bus write to the path
   // byte in the strap cycle overrides the strap load. A write with sel low
   // is still acked but stores nothing.
   always_comb begin
      hold_cfg_d   = hold_cfg_q;
      hold_freq_d  = hold_freq_q;
      sec_in_d     = sec_in_q;
      mixed_d      = mixed_q;
      pdh_d        = pdh_q;
      damp_d       = damp_q;
      lbw_d        = lbw_q;
      soft_d       = soft_q;
      hard_d       = hard_q;
      p_bw_d       = p_bw_q;
      s_bw_d       = s_bw_q;
      strap_seen_d = 1'b1;

      // Strap value lands once, first enabled cycle after reset release
      if (!strap_seen_q) begin
         mixed_d[0] = strap_s2_q;
         pdh_d[0]   = strap_s2_q;
      end

      // Only taken writes store
      if (wr) begin
         unique case (wb_adr_i)
            // Bits 1:0 are reserved and kept at zero
            HLC_ADDR_HOLD_CFG: begin
               hold_cfg_d = {wb_dat_i[7:2], 2'b00};
            end
            // Offset bytes are independent; no shadow, so a live value changes
            HLC_ADDR_HOLD_F0: begin
               hold_freq_d[7:0] = wb_dat_i;
            end
            // Middle offset byte
            HLC_ADDR_HOLD_F1: begin
               hold_freq_d[15:8] = wb_dat_i;
            end
            // Top offset byte holds the sign
            HLC_ADDR_HOLD_F2: begin
               hold_freq_d[23:16] = wb_dat_i;
            end
            // Reserved input codes are stored as written
            HLC_ADDR_SEC_PATH: begin
               sec_in_d = wb_dat_i[7:4];
               mixed_d  = wb_dat_i[3:2];
               pdh_d    = wb_dat_i[1:0];
            end
            // Bits 4:2 are reserved and not stored
            HLC_ADDR_SEC_LOCK: begin
               damp_d = wb_dat_i[7:5];
               lbw_d  = wb_dat_i[1:0];
            end
            // Top bit is the loss-on-hard-alarm enable
            HLC_ADDR_SOFT_LIM: begin
               soft_d = wb_dat_i;
            end
            // Hard limit low byte
            HLC_ADDR_HARD_L0: begin
               hard_d[7:0] = wb_dat_i;
            end
            // Hard limit high byte
            HLC_ADDR_HARD_L1: begin
               hard_d[15:8] = wb_dat_i;
            end
            // Both analog loop fields share one byte
            HLC_ADDR_APLL_BW: begin
               p_bw_d = wb_dat_i[5:4];
               s_bw_d = wb_dat_i[1:0];
            end
            // Status bytes take the write and drop it
            HLC_ADDR_CUR_F0,
            HLC_ADDR_CUR_F1,
            HLC_ADDR_CUR_F2,
            HLC_ADDR_PHASE_0,
            HLC_ADDR_PHASE_1: begin
               hold_cfg_d = hold_cfg_q;
            end
            // Unmapped places store nothing; the read side raises err
            default: begin
               hold_cfg_d = hold_cfg_q;
            end
         endcase
      end
   end

   // Read mux and answer. Data is captured at the taking edge and stands until
   // the next taken request; reserved bits always read as zero.
   always_comb begin
      // Every place is mapped unless the default below says otherwise
      rdata_d = rdata_q;
      hit     = 1'b1;
      unique case (wb_adr_i)
         // Method byte, reserved low bits as zero
         HLC_ADDR_HOLD_CFG: begin
            rdata_d = {hold_cfg_q[7:2], 2'b00};
         end
         // Offset bytes follow the read-back selection
         HLC_ADDR_HOLD_F0: begin
            rdata_d = hold_rd[7:0];
         end
         // Middle offset byte
         HLC_ADDR_HOLD_F1: begin
            rdata_d = hold_rd[15:8];
         end
         // Top offset byte
         HLC_ADDR_HOLD_F2: begin
            rdata_d = hold_rd[23:16];
         end
         // Input select and both output selects
         HLC_ADDR_SEC_PATH: begin
            rdata_d = {sec_in_q, mixed_q, pdh_q};
         end
         // Damping, reserved gap, bandwidth
         HLC_ADDR_SEC_LOCK: begin
            rdata_d = {damp_q, 3'b000, lbw_q};
         end
         // Live frequency; bytes are not captured together, so a carry can tear
         HLC_ADDR_CUR_F0: begin
            rdata_d = sts_i.current_loop_frequency[7:0];
         end
         // Frequency middle byte
         HLC_ADDR_CUR_F1: begin
            rdata_d = sts_i.current_loop_frequency[15:8];
         end
         // Frequency top byte
         HLC_ADDR_CUR_F2: begin
            rdata_d = sts_i.current_loop_frequency[23:16];
         end
         // Enable bit and soft limit
         HLC_ADDR_SOFT_LIM: begin
            rdata_d = soft_q;
         end
         // Hard limit low byte
         HLC_ADDR_HARD_L0: begin
            rdata_d = hard_q[7:0];
         end
         // Hard limit high byte
         HLC_ADDR_HARD_L1: begin
            rdata_d = hard_q[15:8];
         end
         // Live phase error, low byte
         HLC_ADDR_PHASE_0: begin
            rdata_d = sts_i.phase_error_value[7:0];
         end
         // Phase error high byte
         HLC_ADDR_PHASE_1: begin
            rdata_d = sts_i.phase_error_value[15:8];
         end
         // Analog bandwidths with reserved gaps
         HLC_ADDR_APLL_BW: begin
            rdata_d = {2'b00, p_bw_q, 2'b00, s_bw_q};
         end
         // Unmapped place: no data, answered with err
         default: begin
            rdata_d = 8'h00;
            hit     = 1'b0;
         end
      endcase

      // Idle cycles keep the last read data standing on the bus
      if (!req) begin
         rdata_d = rdata_q;
      end
      ack_d = req && hit;
      err_d = req && !hit;
   end

   // Configuration flops; ce low freezes them along with the bus side
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_cfg_q   <= HLC_RST_HOLD_CFG;
         hold_freq_q  <= HLC_RST_HOLD_FREQ;
         sec_in_q     <= HLC_RST_SEC_INPUT;
         // Low bits take the strap in the first enabled cycle after release
         mixed_q      <= 2'h0;
         pdh_q        <= 2'h0;
         damp_q       <= HLC_RST_DAMPING;
         lbw_q        <= HLC_RST_LOCK_BW;
         soft_q       <= HLC_RST_SOFT_LIM;
         hard_q       <= HLC_RST_HARD_LIM;
         p_bw_q       <= HLC_RST_APLL_BW;
         s_bw_q       <= HLC_RST_APLL_BW;
         strap_seen_q <= 1'b0;
      end else if (ce_i) begin
         hold_cfg_q   <= hold_cfg_d;
         hold_freq_q  <= hold_freq_d;
         sec_in_q     <= sec_in_d;
         mixed_q      <= mixed_d;
         pdh_q        <= pdh_d;
         damp_q       <= damp_d;
         lbw_q        <= lbw_d;
         soft_q       <= soft_d;
         hard_q       <= hard_d;
         p_bw_q       <= p_bw_d;
         s_bw_q       <= s_bw_d;
         strap_seen_q <= strap_seen_d;
      end
   end

   // Bus answer flops; ack and err pulse once because req masks a standing answer
   // Read data resets to zero so a read before any request is defined
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
         ack_q   <= 1'b0;
         err_q   <= 1'b0;
      end else if (ce_i) begin
         rdata_q <= rdata_d;
         ack_q   <= ack_d;
         err_q   <= err_d;
      end
   end

   // One lock-loss flop per loop; the alarm only counts while the enable is set
   // Bit 0 is the primary loop, bit 1 the secondary
   for (genvar g = 0; g < 2; g++) begin : g_unl
      logic unl_d;
      logic unl_q;
      // Next value for this loop
      always_comb begin
         unl_d = hard_alarm_i[g] & soft_q[7];
      end

      // Registered, so the flag lags the alarm by one cycle but never glitches
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            unl_q <= 1'b0;
         end else if (ce_i) begin
            unl_q <= unl_d;
         end
      end

      // Each loop drives its own bit of the shared net
      assign unl_all[g] = unl_q;
   end

   // Method decode; manual bit overrides averaging choice
   // Averaging off wins over the fast bit, fast wins over slow
   always_comb begin
      if (hold_cfg_q[HLC_BIT_MANUAL]) begin
         cfg_o.holdover_method = HLC_ACQ_MANUAL;
      end else if (!hold_cfg_q[HLC_BIT_AVG_ON]) begin
         cfg_o.holdover_method = HLC_ACQ_INSTANT;
      end else if (hold_cfg_q[HLC_BIT_FAST]) begin
         cfg_o.holdover_method = HLC_ACQ_FAST;
      end else begin
         cfg_o.holdover_method = HLC_ACQ_SLOW;
      end
      // Remaining fields pass straight from their flops
      cfg_o.temp_holdover_method       = hold_cfg_q[3:2];
      cfg_o.holdover_offset_value      = hold_freq_q;
      cfg_o.secondary_analog_input_sel = sec_in_q;
      cfg_o.secondary_mixed_path_sel   = mixed_q;
      cfg_o.secondary_pdh_path_sel     = pdh_q;
      cfg_o.secondary_locked_damping   = damp_q;
      cfg_o.secondary_locked_bandwidth = lbw_q;
      cfg_o.loss_on_hard_alarm         = soft_q[7];
      cfg_o.soft_limit_value           = soft_q[6:0];
      cfg_o.hard_limit_value           = hard_q;
      cfg_o.primary_analog_bandwidth   = p_bw_q;
      cfg_o.secondary_analog_bandwidth = s_bw_q;
   end

   // Outputs straight from flops
   assign wb_dat_o        = rdata_q;
   assign wb_ack_o        = ack_q;
   assign wb_err_o        = err_q;
   assign loop_unlocked_o = unl_all;

endmodule : hlc_regs

// ===== tb/hlc_regs_assertions.sv
`timescale 1ns/1ps
module hlc_regs_assertions
   import hlc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       wb_we_i,
   input  wire logic [7:0] wb_adr_i,
   input  wire logic [7:0] wb_dat_i,
   input  wire logic       wb_sel_i,
   input  wire logic [7:0] wb_dat_o,
   input  wire logic       wb_ack_o,
   input  wire hlc_sts_t   sts_i,
   input  wire logic [1:0] hard_alarm_i,
   input  wire hlc_cfg_t   cfg_o,
   input  wire logic [1:0] loop_unlocked_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A write lands at the ack edge, so its fields show while ack stands
   wire logic wr = wb_ack_o && wb_we_i && wb_sel_i;
   wire logic rd = wb_ack_o && !wb_we_i;

   property p_method; wr && wb_adr_i == HLC_ADDR_HOLD_CFG |-> cfg_o.holdover_method ==
      (wb_dat_i[7] ? HLC_ACQ_MANUAL : !wb_dat_i[6] ? HLC_ACQ_INSTANT : wb_dat_i[5] ?
      HLC_ACQ_FAST : HLC_ACQ_SLOW) && cfg_o.temp_holdover_method == wb_dat_i[3:2]; endproperty
   a_method: assert property (p_method) else $error("holdover method wrong");
   property p_path; wr && wb_adr_i == HLC_ADDR_SEC_PATH |-> {cfg_o.secondary_analog_input_sel,
      cfg_o.secondary_mixed_path_sel, cfg_o.secondary_pdh_path_sel} == wb_dat_i; endproperty
   a_path: assert property (p_path) else $error("path select wrong");
   property p_lock; wr && wb_adr_i == HLC_ADDR_SEC_LOCK |-> cfg_o.secondary_locked_damping ==
      wb_dat_i[7:5] && cfg_o.secondary_locked_bandwidth == wb_dat_i[1:0]; endproperty
   a_lock: assert property (p_lock) else $error("locked loop fields wrong");
   property p_soft; wr && wb_adr_i == HLC_ADDR_SOFT_LIM |->
      {cfg_o.loss_on_hard_alarm, cfg_o.soft_limit_value} == wb_dat_i; endproperty
   a_soft: assert property (p_soft) else $error("soft limit fields wrong");
   property p_bw; wr && wb_adr_i == HLC_ADDR_APLL_BW |-> {cfg_o.primary_analog_bandwidth,
      cfg_o.secondary_analog_bandwidth} == {wb_dat_i[5:4], wb_dat_i[1:0]}; endproperty
   a_bw: assert property (p_bw) else $error("analog bandwidth wrong");
   property p_unl; ce_i |=> loop_unlocked_o ==
      ($past(hard_alarm_i) & {2{$past(cfg_o.loss_on_hard_alarm)}}); endproperty
   a_unl: assert property (p_unl) else $error("unlocked flag wrong");
   property p_cur; rd && wb_adr_i == HLC_ADDR_CUR_F2 |->
      wb_dat_o == $past(sts_i.current_loop_frequency[23:16]); endproperty
   a_cur: assert property (p_cur) else $error("current frequency read wrong");
   property p_ph; rd && wb_adr_i == HLC_ADDR_PHASE_0 |->
      wb_dat_o == $past(sts_i.phase_error_value[7:0]); endproperty
   a_ph: assert property (p_ph) else $error("phase error read wrong");
endmodule : hlc_regs_assertions

bind hlc_regs hlc_regs_assertions u_hlc_regs_assertions (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sts_i(sts_i),
   .hard_alarm_i(hard_alarm_i), .cfg_o(cfg_o), .loop_unlocked_o(loop_unlocked_o));

// ===== tb/hlc_regs_tb_top.sv
`timescale 1ns/1ps
module hlc_regs_tb_top;
   import hlc_pkg::*;
   logic       clk_i = 1'b0, rst_i = 1'b1, strap = 1'b1, cyc = 1'b0, stb = 1'b0;
   logic       we = 1'b0, sel = 1'b1, ce = 1'b1, ack, err, e;
   logic [7:0] adr = 8'h00, dat = 8'h00, dat_o, q;
   logic [1:0] alarm = 2'b00, unl;
   hlc_cfg_t   cfg;
   hlc_sts_t   sts = {24'h123456, 16'h8abc, 24'h3c2d1e, 24'h5a6b7c};
   int         failures = 0, comparisons = 0;
   // Views of 0x5c..0x6a after reset with strap high, and after writing all ones
   logic [7:0] rst_v [15] = '{8'h44, 8'h00, 8'h00, 8'h00, 8'h45, 8'h60, 8'h56, 8'h34,
                              8'h12, 8'h80, 8'hab, 8'h00, 8'hbc, 8'h8a, 8'h11};
   logic [7:0] one_v [15] = '{8'hfc, 8'h7c, 8'h6b, 8'h5a, 8'hff, 8'he3, 8'h56, 8'h34,
                              8'h12, 8'hff, 8'hff, 8'hff, 8'hbc, 8'h8a, 8'h33};
   logic [7:0] mth [4] = '{8'h00, 8'h40, 8'h60, 8'h80};
   hlc_acq_t   acq [4] = '{HLC_ACQ_INSTANT, HLC_ACQ_SLOW, HLC_ACQ_FAST, HLC_ACQ_MANUAL};

   // Free-running system clock
   always #10 clk_i = ~clk_i;

   hlc_regs u_hlc_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .line_standard_strap_i(strap), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .wb_err_o(err), .sts_i(sts), .hard_alarm_i(alarm), .cfg_o(cfg), .loop_unlocked_o(unl));

   task end_of_test;
      if (failures == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   task chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One classic cycle; held until ack or err, bounded so a dead slave ends the run
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      n = 0;
      do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      if (ack !== 1'b1 && err !== 1'b1) begin failures++; end_of_test(); end
      q = dat_o;
      e = err;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   task rd(input logic [7:0] a, input logic [7:0] x);
      bus(1'b0, a, 8'h00);
      chk($sformatf("read of %h", a), q, x);
   endtask : rd

   // Main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < 15; i++) rd(8'(8'h5c + i), rst_v[i]);
      for (int i = 0; i < 15; i++) bus(1'b1, 8'(8'h5c + i), 8'hff);
      for (int i = 0; i < 15; i++) rd(8'(8'h5c + i), one_v[i]);
      chk("offset", cfg.holdover_offset_value, 24'hffffff);
      chk("hard limit", cfg.hard_limit_value, 24'h00ffff);
      bus(1'b1, HLC_ADDR_HOLD_CFG, 8'h40);
      rd(HLC_ADDR_HOLD_F0, 8'hff);
      bus(1'b1, HLC_ADDR_HOLD_CFG, 8'h50);
      rd(HLC_ADDR_HOLD_F0, 8'h1e);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, HLC_ADDR_HOLD_CFG, mth[i] | 8'(i << 2));
         chk("method", cfg.holdover_method, acq[i]);
         chk("temp method", cfg.temp_holdover_method, 24'(i));
      end
      // Unmapped places are refused, read-only bytes ignore writes
      bus(1'b0, 8'h6b, 8'h00);
      chk("err", e, 1'b1);
      bus(1'b1, 8'h5b, 8'h00);
      chk("err", e, 1'b1);
      bus(1'b1, HLC_ADDR_CUR_F0, 8'h00);
      rd(HLC_ADDR_CUR_F0, 8'h56);
      alarm <= 2'b11;
      repeat (2) @(posedge clk_i);
      chk("unlocked", unl, 2'b11);
      bus(1'b1, HLC_ADDR_SOFT_LIM, 8'h05);
      @(posedge clk_i);
      chk("unlocked", unl, 2'b00);
      sel <= 1'b0;
      bus(1'b1, HLC_ADDR_SOFT_LIM, 8'h80);
      sel <= 1'b1;
      rd(HLC_ADDR_SOFT_LIM, 8'h05);
      // Enable low freezes the bus side: no answer until it returns
      ce <= 1'b0;
      fork
         bus(1'b1, HLC_ADDR_HARD_L1, 8'h12);
         begin
            repeat (3) @(posedge clk_i);
            chk("frozen ack", ack, 1'b0);
            ce <= 1'b1;
         end
      join
      rd(HLC_ADDR_HARD_L1, 8'h12);
      // Second reset with the strap low
      strap <= 1'b0;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(HLC_ADDR_SEC_PATH, 8'h40);
      end_of_test();
   end
endmodule : hlc_regs_tb_top
